// ===== rtl/rtcw_core.sv
// Function
// - advance the time and calendar counter chain once per 1 Hz tick
// - derive the 1 Hz tick from the oscillator, one of four crystal rates
// - optionally take the tick from a 50 or 60 Hz mains input
// - keep seconds, minutes, hours; hours in 12-hour or 24-hour format
// - in 12-hour format, toggle the half-day flag each time hours pass from 11 to 12
// - keep day of week, date, month and year counters
// - all counters in BCD; hours carry 12/24 select and half-day bits
// - counters are read at serial addresses 20h to 26h
// - counters are loaded by writes at addresses A0h to A6h
// - 32-byte RAM read at 00h-1Fh, written at 80h-9Fh
// - three alarm latches; alarm event when all equal the time counters
// - alarm with alarm interrupt enabled sets status bit, drives interrupt low
// - with watchdog enabled the host toggles slave select periodically
// - missed watchdog service pulses CPU reset and sets status bit 6
// - square wave output, seven frequencies from clock control low bits
// - square wave output forced low when power-down starts
// - clock control and interrupt control are read/write and steer the block
// - status register read-only; reading it clears its flags
// - supply mode chosen from supply sense level at end of reset
// - counter reads freeze increments and delay alarm evaluation
// - power-down drives supply enable, square wave, CPU reset low, stops serial
`timescale 1ns/1ps
module rtcw_core import rtcw_pkg::*; #(
	parameter int XTAL_HZ0 = XTAL_HZ_0,
	parameter int XTAL_HZ1 = XTAL_HZ_1,
	parameter int XTAL_HZ2 = XTAL_HZ_2,
	parameter int XTAL_HZ3 = XTAL_HZ_3,
	parameter int PRESC_W = 23,
	parameter int WDOG_SVC_CYC = WDOG_SERVICE_CYC,
	parameter int WDOG_RST_CYC = WDOG_PULSE_CYC,
	parameter int WDOG_W = 26
) (
	// system clock domain
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// serial link, own clock domain
	input wire logic i_sck,
	input wire logic i_ss,
	input wire logic i_mosi,
	output logic o_miso,
	output logic o_miso_oe,
	// time bases and supply sense pins
	input wire logic i_osc,
	input wire logic i_line,
	input wire logic i_system_supply_sense,
	// outputs
	output logic o_irq_n,
	output logic o_cpu_reset_out_n,
	output logic o_square_wave_out,
	output logic o_supply_enable_out,
	output logic o_half_day_flag,
	output logic o_battery_mode
);
	// ---- link domain: shifts bytes on the serial clock
	logic [2:0] bit_cnt;
	logic [6:0] rx_sh;
	logic [7:0] rx_byte;
	logic byte_tgl = 1'b0;
	logic addr_seen;
	logic link_wr;
	logic [7:0] tx_sh;
	logic [7:0] rd_data;
	logic serial_on;

	// frame ends reset the shifter; sck stands still outside frames
	always_ff @(posedge i_sck or negedge i_ss) begin
		if (!i_ss) begin
			bit_cnt <= 3'h0;
			rx_sh <= 7'h00;
			addr_seen <= 1'b0;
			link_wr <= 1'b0;
		end else begin
			bit_cnt <= bit_cnt + 3'h1;
			rx_sh <= {rx_sh[5:0], i_mosi};
			if (bit_cnt == 3'h7 && !addr_seen) begin
				addr_seen <= 1'b1;
				link_wr <= rx_sh[6];
			end
		end
	end

	// byte handed over with a toggle; the byte stays put for eight sck edges
	always_ff @(posedge i_sck) begin
		if (i_ss && bit_cnt == 3'h7) begin
			rx_byte <= {rx_sh, i_mosi};
			byte_tgl <= ~byte_tgl;
		end
	end

	// read data is loaded between bytes; the host leaves sck idle long enough
	always_ff @(negedge i_sck or negedge i_ss) begin
		if (!i_ss)
			tx_sh <= 8'h00;
		else if (bit_cnt == 3'h0)
			tx_sh <= rd_data;
		else
			tx_sh <= {tx_sh[6:0], 1'b0};
	end

	assign o_miso = tx_sh[7];
	assign o_miso_oe = i_ss && addr_seen && !link_wr && serial_on;

	// ---- system domain synchronisers
	logic [4:0] sync_m;
	logic [4:0] sync_s;
	logic [4:0] sync_d;

	always_ff @(posedge i_sys_clk) begin
		if (i_clk_en) begin
			sync_m <= {i_ss, i_osc, i_line, i_system_supply_sense, byte_tgl};
			sync_s <= sync_m;
			sync_d <= sync_s;
		end
	end

	logic ss_s;
	logic ss_rise;
	logic osc_rise;
	logic line_rise;
	logic sense_s;
	logic sense_rise;
	logic byte_evt;
	assign ss_s = sync_s[4];
	assign ss_rise = sync_s[4] && !sync_d[4];
	assign osc_rise = sync_s[3] && !sync_d[3];
	assign line_rise = sync_s[2] && !sync_d[2];
	assign sense_s = sync_s[1];
	assign sense_rise = sync_s[1] && !sync_d[1];
	assign byte_evt = sync_s[0] ^ sync_d[0];

	// ---- registers
	logic [7:0] cc;
	logic [7:0] ic;
	logic [7:0] cnt [N_CNT];
	logic [7:0] next_cnt [N_CNT];
	logic [7:0] alm [N_ALM];
	logic [7:0] ram [RAM_WORDS];
	logic st_alm;
	logic st_wdg;
	logic next_st_alm;
	logic battery_mode;
	logic outputs_on;

	// ---- serial transaction sequencing
	logic have_addr;
	logic sys_wr;
	logic [6:0] ptr;
	logic [6:0] rd_addr;
	logic [7:0] rd_val;
	logic rd_load;
	logic wr_evt;
	logic frozen;

	assign serial_on = outputs_on;
	assign rd_addr = have_addr ? ptr : rx_byte[6:0];
	assign rd_load = byte_evt && serial_on && (have_addr ? !sys_wr : !rx_byte[ADDR_WR_BIT]);
	assign wr_evt = byte_evt && serial_on && have_addr && sys_wr;
	// freeze while a read frame is open
	assign frozen = ss_s && have_addr && !sys_wr;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			have_addr <= 1'b0;
			sys_wr <= 1'b0;
			ptr <= 7'h00;
			rd_data <= 8'h00;
		end else if (i_clk_en) begin
			if (!ss_s && !byte_evt) begin
				have_addr <= 1'b0;
			end else if (byte_evt && serial_on) begin
				have_addr <= 1'b1;
				if (!have_addr)
					sys_wr <= rx_byte[ADDR_WR_BIT];
				// burst: each byte steps to the next location
				ptr <= (have_addr || !rx_byte[ADDR_WR_BIT]) ? rd_addr + 7'h01 : rx_byte[6:0];
				if (rd_load)
					rd_data <= rd_val;
			end
		end
	end

	// counter read window, RAM read window
	always_comb begin
		rd_val = 8'h00;
		if (rd_addr <= A_RAM_LAST)
			rd_val = ram[rd_addr[4:0]];
		else if (rd_addr >= A_CNT_FIRST && rd_addr <= A_CNT_LAST)
			rd_val = cnt[rd_addr[2:0]];
		else if (rd_addr == A_STATUS)
			rd_val = 8'(({7'h00, st_wdg} << ST_WDOG_BIT) | ({7'h00, st_alm} << ST_ALM_BIT));
		else if (rd_addr == A_CLK_CTRL)
			rd_val = cc;
		else if (rd_addr == A_INT_CTRL)
			rd_val = ic;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_clk_en && wr_evt && ptr <= A_RAM_LAST)
			ram[ptr[4:0]] <= rx_byte;
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cc <= CLK_CTRL_RST;
			ic <= INT_CTRL_RST;
			alm <= '{default: TIME_RST};
		end else if (i_clk_en) begin
			if (sense_rise)
				ic[IC_PD_BIT] <= 1'b0;
			if (wr_evt && ptr == A_CLK_CTRL)
				cc <= rx_byte;
			if (wr_evt && ptr == A_INT_CTRL)
				ic <= rx_byte;
			if (wr_evt && ptr >= A_ALM_FIRST && ptr <= A_ALM_LAST)
				alm[ptr[1:0]] <= rx_byte;
		end
	end

	// mode caught from the synchronised sense level while reset is held
	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			battery_mode <= !sense_s;
	end
	assign o_battery_mode = battery_mode;
	// in either mode the outputs need system supply present and no power-down
	assign outputs_on = sense_s && !ic[IC_PD_BIT];

	// ---- time base
	logic [PRESC_W-1:0] presc;
	logic [PRESC_W-1:0] xlim;
	logic [5:0] line_cnt;
	logic [5:0] line_lim;
	logic [5:0] div_cnt;
	logic use_line;
	logic tick;

	assign use_line = cc[CC_LINE_BIT];
	assign line_lim = cc[CC_LINE60_BIT] ? 6'(LINE_PER_S_60 - 1) : 6'(LINE_PER_S_50 - 1);

	always_comb begin
		case (cc[CC_XSEL_LSB +: 2])
			2'h0: xlim = PRESC_W'(XTAL_HZ0 - 1);
			2'h1: xlim = PRESC_W'(XTAL_HZ1 - 1);
			2'h2: xlim = PRESC_W'(XTAL_HZ2 - 1);
			default: xlim = PRESC_W'(XTAL_HZ3 - 1);
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			presc <= '0;
			line_cnt <= 6'h00;
			div_cnt <= 6'h00;
			tick <= 1'b0;
		end else if (i_clk_en) begin
			tick <= 1'b0;
			if (osc_rise)
				div_cnt <= div_cnt + 6'h01;
			if (use_line && line_rise) begin
				line_cnt <= (line_cnt >= line_lim) ? 6'h00 : line_cnt + 6'h01;
				tick <= line_cnt >= line_lim;
			end else if (!use_line && osc_rise) begin
				presc <= (presc >= xlim) ? '0 : presc + PRESC_W'(1);
				tick <= presc >= xlim;
			end
		end
	end

	// square wave select; forced low in power-down
	logic sq_sel_val;
	always_comb begin
		case (cc[CC_SQ_LSB +: 3])
			SQ_OFF: sq_sel_val = 1'b0;
			SQ_HALF: sq_sel_val = use_line ? (line_cnt > (line_lim >> 1)) : (presc > (xlim >> 1));
			default: sq_sel_val = div_cnt[cc[CC_SQ_LSB +: 3]];
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst)
			o_square_wave_out <= 1'b0;
		else if (i_clk_en)
			o_square_wave_out <= outputs_on && sq_sel_val;
	end

	// ---- clock and calendar chain
	logic pending;
	logic advance;
	logic c_min;
	logic c_hr;
	logic c_day;
	logic c_mon;
	logic c_yr;
	assign advance = pending && !frozen;

	always_comb begin
		next_cnt = cnt;
		c_min = cnt[I_SEC] == 8'h59;
		c_hr = c_min && cnt[I_MIN] == 8'h59;
		c_day = 1'b0;
		next_cnt[I_SEC] = c_min ? TIME_RST : bcd_inc(cnt[I_SEC]);
		if (c_min)
			next_cnt[I_MIN] = c_hr ? TIME_RST : bcd_inc(cnt[I_MIN]);
		if (c_hr && cnt[I_HR][HR_12H_BIT]) begin
			case (cnt[I_HR][4:0])
				5'h11: begin
					next_cnt[I_HR][4:0] = 5'h12;
					next_cnt[I_HR][HR_PM_BIT] = !cnt[I_HR][HR_PM_BIT];
					c_day = cnt[I_HR][HR_PM_BIT];
				end
				5'h12: next_cnt[I_HR][4:0] = 5'h01;
				default: next_cnt[I_HR][4:0] = 5'(bcd_inc({3'h0, cnt[I_HR][4:0]}));
			endcase
		end else if (c_hr) begin
			c_day = cnt[I_HR][5:0] == 6'h23;
			next_cnt[I_HR][5:0] = c_day ? 6'h00 : 6'(bcd_inc({2'h0, cnt[I_HR][5:0]}));
		end
		c_mon = c_day && cnt[I_DATE] >= month_days(cnt[I_MON], cnt[I_YEAR]);
		c_yr = c_mon && cnt[I_MON] == 8'h12;
		if (c_day) begin
			next_cnt[I_DOW] = (cnt[I_DOW] == 8'h07) ? DATE_RST : bcd_inc(cnt[I_DOW]);
			next_cnt[I_DATE] = c_mon ? DATE_RST : bcd_inc(cnt[I_DATE]);
		end
		if (c_mon)
			next_cnt[I_MON] = c_yr ? DATE_RST : bcd_inc(cnt[I_MON]);
		if (c_yr)
			next_cnt[I_YEAR] = (cnt[I_YEAR] == 8'h99) ? TIME_RST : bcd_inc(cnt[I_YEAR]);
	end

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			cnt <= '{TIME_RST, TIME_RST, TIME_RST, DATE_RST, DATE_RST, DATE_RST, TIME_RST};
			pending <= 1'b0;
		end else if (i_clk_en) begin
			// a tick seen during a read waits here
			if (tick)
				pending <= 1'b1;
			else if (advance)
				pending <= 1'b0;
			if (advance)
				cnt <= next_cnt;
			// host load wins over a step in the same cycle
			if (wr_evt && ptr >= A_CNT_FIRST && ptr <= A_CNT_LAST)
				cnt[ptr[2:0]] <= rx_byte;
		end
	end
	assign o_half_day_flag = cnt[I_HR][HR_12H_BIT] && cnt[I_HR][HR_PM_BIT];

	// ---- alarm and status
	logic alm_chk;
	logic alarm_evt;
	logic st_clr;
	assign st_clr = rd_load && rd_addr == A_STATUS;
	// compared once the counters have settled after a step
	assign alarm_evt = alm_chk && alm[0] == cnt[I_SEC] && alm[1] == cnt[I_MIN]
		&& alm[2] == cnt[I_HR];
	// a new alarm beats a clearing read
	assign next_st_alm = (alarm_evt && ic[IC_ALM_BIT]) || (st_alm && !st_clr);

	// ---- watchdog
	logic [WDOG_W-1:0] wcnt;
	logic [WDOG_W-1:0] pcnt;
	logic [WDOG_W-1:0] next_pcnt;
	logic wd_fire;
	// service by slave-select edges within the interval
	assign wd_fire = ic[IC_WDOG_BIT] && !ss_rise && wcnt == WDOG_W'(WDOG_SVC_CYC - 1);
	assign next_pcnt = wd_fire ? WDOG_W'(WDOG_RST_CYC) : (pcnt != '0) ? pcnt - WDOG_W'(1) : pcnt;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			alm_chk <= 1'b0;
			st_alm <= 1'b0;
			st_wdg <= 1'b0;
			o_irq_n <= 1'b1;
			wcnt <= '0;
			pcnt <= '0;
			o_cpu_reset_out_n <= 1'b0;
			o_supply_enable_out <= 1'b0;
		end else if (i_clk_en) begin
			alm_chk <= advance;
			st_alm <= next_st_alm;
			o_irq_n <= !(next_st_alm && ic[IC_ALM_BIT]);
			// flag set beats a clearing read
			st_wdg <= wd_fire || (st_wdg && !st_clr);
			wcnt <= (!ic[IC_WDOG_BIT] || ss_rise || wd_fire) ? '0 : wcnt + WDOG_W'(1);
			pcnt <= next_pcnt;
			// CPU reset held low by pulse, power-down or missing supply
			o_cpu_reset_out_n <= outputs_on && next_pcnt == '0;
			o_supply_enable_out <= outputs_on;
		end
	end

	// ---- assertions
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst || !i_clk_en);

	sequence s_rst_low;
		!o_cpu_reset_out_n [*8];
	endsequence
	sequence s_top_of_hour;
		advance && !wr_evt && cnt[I_SEC] == 8'h59 && cnt[I_MIN] == 8'h59;
	endsequence

	a_tick_step: assert property (advance && !tick |=> !pending)
		else $error("pending tick not consumed");
	a_freeze_hold: assert property (frozen && pending && !wr_evt |=> pending && $stable(cnt[I_SEC]))
		else $error("counters moved during a read");
	a_sec_wrap: assert property (advance && !wr_evt && cnt[I_SEC] == 8'h59 |=> cnt[I_SEC] == 8'h00)
		else $error("seconds did not wrap");
	a_date_roll: assert property (s_top_of_hour and (!cnt[I_HR][HR_12H_BIT] && cnt[I_HR][5:0] == 6'h23
		&& cnt[I_DATE] == month_days(cnt[I_MON], cnt[I_YEAR])) |=> cnt[I_DATE] == DATE_RST)
		else $error("date did not roll over");
	a_half_day: assert property (s_top_of_hour and (cnt[I_HR][HR_12H_BIT] && cnt[I_HR][4:0] == 5'h11)
		|=> cnt[I_HR][HR_PM_BIT] != $past(cnt[I_HR][HR_PM_BIT]))
		else $error("half-day flag did not toggle");
	a_alarm_irq: assert property (alarm_evt && ic[IC_ALM_BIT] |=> st_alm && !o_irq_n)
		else $error("alarm did not raise interrupt");
	a_status_clr: assert property (st_clr && !alarm_evt && !wd_fire |=> !st_alm && !st_wdg)
		else $error("status read did not clear flags");
	a_wdog_pulse: assert property (wd_fire && WDOG_RST_CYC >= 8 |=> st_wdg ##0 s_rst_low)
		else $error("watchdog reset pulse missing");
	a_pd_outputs: assert property (ic[IC_PD_BIT] |=> !o_supply_enable_out && !o_square_wave_out
		&& !o_cpu_reset_out_n)
		else $error("power-down outputs not low");
endmodule : rtcw_core

// ===== rtl/rtcw_pkg.sv
package rtcw_pkg;
	localparam int SYS_CLK_HZ = 50_000_000;

	// serial address byte: top bit marks a write, low seven bits the location
	localparam int ADDR_WR_BIT = 7;
	localparam logic [6:0] A_RAM_LAST = 7'h1f;
	localparam logic [6:0] A_CNT_FIRST = 7'h20;
	localparam logic [6:0] A_CNT_LAST = 7'h26;
	localparam logic [6:0] A_ALM_FIRST = 7'h28;
	localparam logic [6:0] A_ALM_LAST = 7'h2a;
	localparam logic [6:0] A_STATUS = 7'h30;
	localparam logic [6:0] A_CLK_CTRL = 7'h31;
	localparam logic [6:0] A_INT_CTRL = 7'h32;
	localparam int RAM_WORDS = 32;

	// time and calendar counter indices
	localparam int I_SEC = 0;
	localparam int I_MIN = 1;
	localparam int I_HR = 2;
	localparam int I_DOW = 3;
	localparam int I_DATE = 4;
	localparam int I_MON = 5;
	localparam int I_YEAR = 6;
	localparam int N_CNT = 7;
	localparam int N_ALM = 3;

	// field positions
	localparam int HR_12H_BIT = 7;
	localparam int HR_PM_BIT = 5;
	localparam int CC_SQ_LSB = 0;
	localparam int CC_LINE60_BIT = 3;
	localparam int CC_XSEL_LSB = 4;
	localparam int CC_LINE_BIT = 6;
	localparam int IC_WDOG_BIT = 7;
	localparam int IC_PD_BIT = 6;
	localparam int IC_ALM_BIT = 4;
	localparam int ST_WDOG_BIT = 6;
	localparam int ST_ALM_BIT = 3;
	localparam logic [2:0] SQ_HALF = 3'h6;
	localparam logic [2:0] SQ_OFF = 3'h7;

	// reset values
	localparam logic [7:0] CLK_CTRL_RST = 8'h00;
	localparam logic [7:0] INT_CTRL_RST = 8'h00;
	localparam logic [7:0] TIME_RST = 8'h00;
	localparam logic [7:0] DATE_RST = 8'h01;

	// time bases and timing
	localparam int LINE_PER_S_50 = 50;
	localparam int LINE_PER_S_60 = 60;
	localparam int XTAL_HZ_0 = 32768;
	localparam int XTAL_HZ_1 = 1048576;
	localparam int XTAL_HZ_2 = 2097152;
	localparam int XTAL_HZ_3 = 4194304;
	localparam int WDOG_SERVICE_MS = 500;
	localparam int WDOG_PULSE_US = 100;
	localparam int WDOG_SERVICE_CYC = SYS_CLK_HZ / 1000 * WDOG_SERVICE_MS;
	localparam int WDOG_PULSE_CYC = SYS_CLK_HZ / 1_000_000 * WDOG_PULSE_US;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction : bcd_inc

	function automatic logic is_leap(input logic [7:0] y);
		is_leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
			: (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
	endfunction : is_leap

	function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02: month_days = is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default: month_days = 8'h31;
		endcase
	endfunction : month_days
endpackage : rtcw_pkg

// ===== testbench/rtcw_core_bench.sv
`timescale 1ns/1ps
module rtcw_core_bench import rtcw_pkg::*;;
	localparam int WD_SVC = 200;
	localparam int WD_RST = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic clk_en = 1'b1;
	logic osc = 1'b0;
	logic line = 1'b0;
	logic sense = 1'b1;
	logic osc_run = 1'b0;
	logic oe_seen = 1'b0;
	logic cpu_low = 1'b0;
	logic [1:0] div = 2'h0;
	wire sck, ss, mosi, miso, oe, irq_n, cpu_n, sq, supply_enable_out, half, batt, miso_w;
	int failures = 0;
	int checks_done = 0;
	logic [55:0] t_in [5] = '{56'h24022807235959, 56'h23022803235959, 56'h99123105235959,
		56'h05043002915959, 56'h05063002b15959};
	logic [55:0] t_out [5] = '{56'h24022901000000, 56'h23030104000000, 56'h00010106000000,
		56'h05043002b20000, 56'h05070103920000};
	logic [7:0] sq_cc [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h16, 8'h36};
	int sq_per [9] = '{16, 32, 64, 128, 256, 512, 128, 256, 800};
	// an undriven data line shows a pattern that changes every cycle
	assign miso_w = oe ? miso : clk;
	initial forever #10 clk = ~clk;
	// oscillator of eight system cycles, well under a quarter of the clock
	always @(posedge clk) begin
		div <= div + 2'h1;
		if (osc_run && div == 2'h3)
			osc <= ~osc;
		if (oe)
			oe_seen <= 1'b1;
		if (!cpu_n)
			cpu_low <= 1'b1;
	end
	rtcw_core #(
		.XTAL_HZ0(16), .XTAL_HZ1(32), .XTAL_HZ2(64), .XTAL_HZ3(100),
		.WDOG_SVC_CYC(WD_SVC), .WDOG_RST_CYC(WD_RST)
	) i_dut (
		.i_sys_clk(clk), .i_rst(rst), .i_clk_en(clk_en), .i_sck(sck), .i_ss(ss),
		.i_mosi(mosi), .o_miso(miso), .o_miso_oe(oe), .i_osc(osc), .i_line(line),
		.i_system_supply_sense(sense), .o_irq_n(irq_n), .o_cpu_reset_out_n(cpu_n),
		.o_square_wave_out(sq), .o_supply_enable_out(supply_enable_out), .o_half_day_flag(half),
		.o_battery_mode(batt)
	);
	rtcw_host h (.o_sck(sck), .o_ss(ss), .o_mosi(mosi), .i_miso(miso_w));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		h.dat[0] = d;
		h.frame({1'b1, a}, 1);
	endtask : wr
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		h.frame({1'b0, a}, 1);
		d = h.dat[0];
	endtask : rd
	task automatic pulses(input int n);
		repeat (n) begin
			@(posedge clk);
			line <= 1'b1;
			repeat (3) @(posedge clk);
			line <= 1'b0;
			repeat (2) @(posedge clk);
		end
		repeat (12) @(posedge clk);
	endtask : pulses
	task automatic rise(inout int n);
		while (sq !== 1'b0 && n < 4000) begin
			@(posedge clk);
			n++;
		end
		while (sq !== 1'b1 && n < 4000) begin
			@(posedge clk);
			n++;
		end
	endtask : rise
	task automatic quiet(output int n);
		n = 0;
		repeat (400) begin
			@(posedge clk);
			if (sq !== 1'b0)
				n++;
		end
	endtask : quiet
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial begin
		logic [7:0] v, u;
		logic [7:0] ram [32];
		int n;
		void'($urandom(32'h58a3));
		// three edges in reset: the sense synchroniser fills by the last one
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		check(16'(supply_enable_out & cpu_n & irq_n & ~batt), 16'h1);
		h.frame({1'b0, A_CNT_FIRST}, N_CNT);
		for (int i = 0; i < N_CNT; i++)
			check(16'(h.dat[i]), (i >= I_DOW && i <= I_MON) ? 16'(DATE_RST) : 16'(TIME_RST));
		for (int i = 0; i < RAM_WORDS; i++)
			h.dat[i] = 8'($urandom);
		ram = h.dat;
		h.frame(8'h80, RAM_WORDS);
		h.frame(8'h00, RAM_WORDS);
		for (int i = 0; i < RAM_WORDS; i++)
			check(16'(h.dat[i]), 16'(ram[i]));
		// the tick now comes from bench line pulses, 50 to a second, so each second is exact
		wr(A_CLK_CTRL, 8'h40);
		for (int k = 0; k < 5; k++) begin
			for (int i = 0; i < N_CNT; i++)
				h.dat[i] = t_in[k][8 * i +: 8];
			// alarm interrupt enable is still clear while loading
			h.frame({1'b1, A_CNT_FIRST}, N_CNT);
			pulses(LINE_PER_S_50);
			h.frame({1'b0, A_CNT_FIRST}, N_CNT);
			for (int i = 0; i < N_CNT; i++)
				check(16'(h.dat[i]), 16'(t_out[k][8 * i +: 8]));
			check(16'(half), 16'(t_out[k][23] & t_out[k][21]));
		end
		wr(A_CLK_CTRL, 8'h48);
		pulses(LINE_PER_S_60 - 1);
		rd(A_CNT_FIRST, v);
		check(16'(v), 16'h0);
		pulses(1);
		rd(A_CNT_FIRST, v);
		check(16'(v), 16'h1);
		// a tick inside an open read frame must not split the minutes from the seconds
		wr(A_CNT_FIRST, 8'h59);
		wr(A_CNT_FIRST + 7'h01, 8'h10);
		pulses(LINE_PER_S_60 - 1);
		fork
			h.frame({1'b0, A_CNT_FIRST}, 2);
			begin
				repeat (35) @(posedge clk);
				pulses(1);
			end
		join
		check({h.dat[1], h.dat[0]}, 16'h1059);
		rd(A_CNT_FIRST + 7'h01, v);
		check(16'(v), 16'h11);
		// with the clock enable low a full second of mains pulses is ignored
		clk_en <= 1'b0;
		pulses(LINE_PER_S_60);
		clk_en <= 1'b1;
		rd(A_CNT_FIRST, v);
		check(16'(v), 16'h0);
		wr(A_CNT_FIRST + 7'(I_HR), 8'h10);
		h.dat[0] = 8'h01;
		h.dat[1] = 8'h11;
		h.dat[2] = 8'h10;
		h.frame({1'b1, A_ALM_FIRST}, N_ALM);
		wr(A_INT_CTRL, 8'h01 << IC_ALM_BIT);
		wr(A_CLK_CTRL, 8'h40);
		check(16'(irq_n), 16'h1);
		pulses(LINE_PER_S_50);
		check(16'(irq_n), 16'h0);
		rd(A_STATUS, v);
		check(16'(v), 16'(8'h01 << ST_ALM_BIT));
		check(16'(irq_n), 16'h1);
		wr(A_STATUS, 8'hff);
		rd(A_STATUS, v);
		check(16'(v), 16'h0);
		u = 8'($urandom) & 8'h3f;
		wr(A_CLK_CTRL, u);
		wr(A_INT_CTRL, ~u & 8'h3f);
		rd(A_CLK_CTRL, v);
		check(16'(v), 16'(u));
		rd(A_INT_CTRL, v);
		check(16'(v), 16'(~u & 8'h3f));
		wr(A_INT_CTRL, 8'h00);
		osc_run <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			wr(A_CLK_CTRL, sq_cc[i]);
			n = 0;
			repeat (2) rise(n);
			n = 0;
			rise(n);
			check(16'(n), 16'(sq_per[i]));
		end
		wr(A_CLK_CTRL, {5'h00, SQ_OFF});
		quiet(n);
		check(16'(n), 16'h0);
		wr(A_CLK_CTRL, 8'h06);
		wr(A_INT_CTRL, 8'h01 << IC_PD_BIT);
		repeat (4) @(posedge clk);
		check(16'({supply_enable_out, cpu_n}), 16'h0);
		quiet(n);
		check(16'(n), 16'h0);
		oe_seen = 1'b0;
		rd(A_CLK_CTRL, v);
		check(16'(oe_seen), 16'h0);
		sense <= 1'b0;
		repeat (8) @(posedge clk);
		sense <= 1'b1;
		repeat (8) @(posedge clk);
		check(16'({supply_enable_out, cpu_n}), 16'h3);
		rd(A_INT_CTRL, v);
		check(16'(v), 16'h0);
		wr(A_INT_CTRL, 8'h01 << IC_WDOG_BIT);
		cpu_low = 1'b0;
		repeat (4) begin
			repeat (150) @(posedge clk);
			h.kick();
		end
		check(16'(cpu_low), 16'h0);
		n = 0;
		while (cpu_n === 1'b1 && n < 400) begin
			@(posedge clk);
			n++;
		end
		check(16'(n > 175 && n < 215), 16'h1);
		n = 0;
		while (cpu_n === 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		check(16'(n), 16'(WD_RST));
		rd(A_STATUS, v);
		check(16'(v), 16'(8'h01 << ST_WDOG_BIT));
		wr(A_INT_CTRL, 8'h00);
		rst <= 1'b1;
		sense <= 1'b0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		repeat (4) @(posedge clk);
		check(16'({batt, supply_enable_out, cpu_n}), 16'h4);
		tally_and_finish();
	end
	initial begin
		#2ms;
		failures++;
		tally_and_finish();
	end
endmodule : rtcw_core_bench

// ===== testbench/rtcw_host.sv
`timescale 1ns/1ps
module rtcw_host (
	// serial link to the device
	output logic o_sck,
	output logic o_ss,
	output logic o_mosi,
	input wire logic i_miso
);
	logic [7:0] dat [32];
	// link clock stands high outside frames
	initial begin
		o_sck = 1'b1;
		o_ss = 1'b0;
		o_mosi = 1'b0;
	end
	// one byte, msb first, data sampled on the rising edge
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int b = 7; b >= 0; b--) begin
			o_sck = 1'b0;
			o_mosi = tx[b];
			#24;
			o_sck = 1'b1;
			rx[b] = i_miso;
			#24;
		end
		// idle gap lets the byte cross into the system domain
		#200;
		// a released data line must not keep its last level
		o_mosi = ~o_mosi;
	endtask : xfer
	// address byte picks read or write, then a burst of n bytes
	task automatic frame(input logic [7:0] addr, input int n);
		logic [7:0] rx;
		#7;
		o_ss = 1'b1;
		#100;
		xfer(addr, rx);
		for (int i = 0; i < n; i++) begin
			xfer(addr[7] ? dat[i] : 8'h00, rx);
			if (!addr[7])
				dat[i] = rx;
		end
		o_ss = 1'b0;
		#200;
	endtask : frame
	// select toggled with no clock edges
	task automatic kick;
		#7;
		o_ss = 1'b1;
		#100;
		o_ss = 1'b0;
		#100;
	endtask : kick
endmodule : rtcw_host
